// *** shared/sdwl_pkg.sv ***
package sdwl_pkg;
  // Word layout on the link
  localparam int unsigned SDWL_WORD_BITS = 16;
  localparam int unsigned SDWL_DATA_BITS = 14;
  localparam int unsigned SDWL_SUB_BITS  = 2;
  localparam int unsigned SDWL_CNT_BITS  = 5;
  localparam logic [4:0]  SDWL_CNT_ZERO  = 5'h00;
  localparam logic [4:0]  SDWL_CNT_ONE   = 5'h01;
  localparam logic [4:0]  SDWL_CNT_FULL  = 5'h10;
  localparam logic [15:0] SDWL_WORD_ZERO = 16'h0000;
  localparam logic [1:0]  SDWL_SUB_ZERO  = 2'h0;
  // Latch codes after clear or power-up
  localparam logic [13:0] SDWL_CODE_UNIPOLAR = 14'h0000;
  localparam logic [13:0] SDWL_CODE_BIPOLAR  = 14'h2000;
  // Host serial clock divider: half period in system clocks (50 percent duty)
  localparam logic [3:0]  SDWL_HALF_DIV  = 4'h2;
  localparam logic [3:0]  SDWL_DIV_ZERO  = 4'h0;
  localparam logic [3:0]  SDWL_DIV_ONE   = 4'h1;

  typedef enum logic [1:0] {
    SDWL_IDLE  = 2'b00,
    SDWL_SETUP = 2'b01,
    SDWL_SHIFT = 2'b10,
    SDWL_END   = 2'b11
  } sdwl_state_t;
endpackage

// *** shared/sdwl_link_if.sv ***
`timescale 1ns/1ns
interface sdwl_link_if;
  logic frame_n;
  logic serial_clk;
  logic serial_data;
  logic async_clear_n;

  modport host (output frame_n, output serial_clk, output serial_data, output async_clear_n);
  modport device (input frame_n, input serial_clk, input serial_data, input async_clear_n);
endinterface

// *** rtl/sdwl_host.sv ***
`timescale 1ns/1ns
// Host end: sends one 16-bit word per request, MSB first, sub-bits zero.
module sdwl_host (
  // System clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                clk_en,
  // User request side
  input  wire logic                req_valid,
  input  wire logic [13:0]         req_code,
  output logic                     req_ready,
  input  wire logic                clear_req,
  // Link
  sdwl_link_if.host                link
);
  import sdwl_pkg::*;

  sdwl_state_t                     state;
  sdwl_state_t                     next_state;
  logic [15:0]                     shreg;
  logic [15:0]                     next_shreg;
  logic [4:0]                      cnt;
  logic [4:0]                      next_cnt;
  logic [3:0]                      div;
  logic [3:0]                      next_div;
  logic                            sclk;
  logic                            next_sclk;
  logic                            frame_n;
  logic                            next_frame_n;
  logic                            clr_n;
  logic                            next_clr_n;
  logic                            tick;

  assign tick      = (div == SDWL_HALF_DIV - SDWL_DIV_ONE);
  assign req_ready = (state == SDWL_IDLE) && clear_req == 1'b0;

  // Sequencer: frame low, 16 rising edges, then frame high
  always_comb begin
    next_state   = state;
    next_shreg   = shreg;
    next_cnt     = cnt;
    next_div     = tick ? SDWL_DIV_ZERO : div + SDWL_DIV_ONE;
    next_sclk    = sclk;
    next_frame_n = frame_n;
    next_clr_n   = ~clear_req;
    case (state)
      SDWL_IDLE: begin
        next_div = SDWL_DIV_ZERO;
        if (req_valid && req_ready) begin
          next_shreg   = {req_code, SDWL_SUB_ZERO};
          next_frame_n = 1'b0;
          next_cnt     = SDWL_CNT_ZERO;
          next_state   = SDWL_SETUP;
        end
      end
      SDWL_SETUP: begin
        if (tick) begin
          next_state = SDWL_SHIFT;
        end
      end
      SDWL_SHIFT: begin
        // Data changes on falling edge, held stable across the rising edge
        if (tick) begin
          next_sclk = ~sclk;
          if (sclk) begin
            next_shreg = {shreg[14:0], 1'b0};
            if (cnt == SDWL_CNT_FULL) begin
              next_sclk  = 1'b0;
              next_state = SDWL_END;
            end
          end else begin
            next_cnt = cnt + SDWL_CNT_ONE;
          end
        end
      end
      SDWL_END: begin
        // Frame held low through all 16 clocks, released only now
        if (tick) begin
          next_frame_n = 1'b1;
          next_state   = SDWL_IDLE;
        end
      end
      default: begin
        next_state = SDWL_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state   <= SDWL_IDLE;
      shreg   <= SDWL_WORD_ZERO;
      cnt     <= SDWL_CNT_ZERO;
      div     <= SDWL_DIV_ZERO;
      sclk    <= 1'b0;
      frame_n <= 1'b1;
      clr_n   <= 1'b1;
    end else if (clk_en) begin
      state   <= next_state;
      shreg   <= next_shreg;
      cnt     <= next_cnt;
      div     <= next_div;
      sclk    <= next_sclk;
      frame_n <= next_frame_n;
      clr_n   <= next_clr_n;
    end
  end

  assign link.frame_n       = frame_n;
  assign link.serial_clk    = sclk;
  assign link.serial_data   = shreg[15];
  assign link.async_clear_n = clr_n;
endmodule

// *** rtl/sdwl_device.sv ***
`timescale 1ns/1ns
// Summary of operation
// - Data accepted only while frame is low
// - Sample data on each rising serial clock
// - Word is 16 bits, two zero sub-bits
// - Frame rise after 16 bits loads latch
// - Host keeps frame low all 16 clocks
// - Host rewrites full word after corruption (sdwl_host never sees load_err and does not resend)
// - Clear low forces latch asynchronously
// - Host serial clock duty 40 to 60 percent
// - Power-up latch code depends on variant
module sdwl_device #(
  parameter bit BIPOLAR = 1'b0
) (
  // Link (the serial clock clocks the shift register; frame rise clocks the latch)
  sdwl_link_if.device              link,
  // Power-up reset and freeze
  input  wire logic                rstn,
  input  wire logic                clk_en,
  // System side view of the latch
  input  wire logic                clk_sys,
  output logic [13:0]              latch_code,
  output logic [13:0]              latch_code_sys,
  output logic                     load_err
);
  import sdwl_pkg::*;

  // Variant code is fixed at elaboration, so the async reset branch still loads a constant
  localparam logic [13:0]          RESET_CODE = BIPOLAR ? SDWL_CODE_BIPOLAR : SDWL_CODE_UNIPOLAR;

  logic [15:0]                     shreg;
  logic [15:0]                     next_shreg;
  logic [4:0]                      cnt;
  logic [4:0]                      next_cnt;
  logic [13:0]                     word_code;
  logic [4:0]                      word_cnt;
  logic                            word_tgl;
  logic                            latch_rstn;
  logic [2:0]                      sync_tgl;
  logic [13:0]                     next_code_sys;
  logic                            next_err;

  assign latch_rstn = rstn & link.async_clear_n;

  // Shift path: counter saturates so extra bits do not wrap
  always_comb begin
    next_shreg = {shreg[14:0], link.serial_data};
    next_cnt   = (cnt == SDWL_CNT_FULL) ? cnt : cnt + SDWL_CNT_ONE;
  end

  // Shift register, cleared by frame high so every frame starts fresh
  always_ff @(posedge link.serial_clk or posedge link.frame_n) begin
    if (link.frame_n) begin
      shreg <= SDWL_WORD_ZERO;
      cnt   <= SDWL_CNT_ZERO;
    end else if (clk_en) begin
      shreg <= next_shreg;
      cnt   <= next_cnt;
    end
  end

  // Frame rise samples the finished word; clear wins asynchronously
  always_ff @(posedge link.frame_n or negedge latch_rstn) begin
    if (!latch_rstn) begin
      latch_code <= RESET_CODE;
    end else if (clk_en) begin
      if (cnt == SDWL_CNT_FULL) begin
        latch_code <= shreg[15:2];
      end
    end
  end

  // Frame report for the system side; clear must not toggle it or a false short frame shows
  always_ff @(posedge link.frame_n or negedge rstn) begin
    if (!rstn) begin
      word_code <= RESET_CODE;
      word_cnt  <= SDWL_CNT_ZERO;
      word_tgl  <= 1'b0;
    end else if (clk_en) begin
      word_code <= shreg[15:2];
      word_cnt  <= cnt;
      word_tgl  <= ~word_tgl;
    end
  end

  // Event crossing into the system domain by toggle
  always_comb begin
    next_code_sys = latch_code_sys;
    next_err      = load_err;
    if (sync_tgl[2] != sync_tgl[1]) begin
      next_err = (word_cnt != SDWL_CNT_FULL); // short frame: host must reload
      if (!next_err) begin
        next_code_sys = word_code;
      end
    end
  end

  // System side registers; the latch output itself is async-cleared
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync_tgl       <= 3'h0;
      latch_code_sys <= RESET_CODE;
      load_err       <= 1'b0;
    end else if (clk_en) begin
      sync_tgl       <= {sync_tgl[1:0], word_tgl};
      latch_code_sys <= next_code_sys;
      load_err       <= next_err;
    end
  end
endmodule

// *** tb/sdwl_props.sv ***
`timescale 1ns/1ns
module sdwl_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Link
  input wire logic frame_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic async_clear_n
);
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic       clk_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Rising link edges seen in this frame
  always_comb begin
    next_cnt = cnt;
    if (frame_n) begin
      next_cnt = 5'h00;
    end else if (serial_clk && !clk_q) begin
      next_cnt = cnt + 5'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt   <= 5'h00;
      clk_q <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      clk_q <= serial_clk;
    end
  end
  a_idle_no_clk: assert property (frame_n |-> !serial_clk) else $error("clock outside frame");
  a_frame_setup: assert property ($fell(frame_n) |-> !serial_clk [*2]) else $error("no setup");
  a_frame_gap: assert property ($rose(frame_n) |=> frame_n) else $error("no idle gap");
  a_data_held: assert property (serial_clk |-> $stable(serial_data)) else $error("data moved");
  a_count_cap: assert property (cnt <= 5'h10) else $error("too many bits");
  a_sub_zero: assert property ($rose(serial_clk) && cnt >= 5'h0E |-> !serial_data)
    else $error("sub-bit not zero");
  a_full_len: assert property ($rose(frame_n) |-> cnt == 5'h10) else $error("frame not 16");
  a_high_time: assert property ($rose(serial_clk) |-> serial_clk ##1 serial_clk ##1 !serial_clk)
    else $error("bad high time");
  a_low_time: assert property ($fell(serial_clk) && !frame_n |-> !serial_clk [*2])
    else $error("bad low time");
  // Main traffic seen
  cover property ($rose(frame_n) && cnt == 5'h10);
  cover property ($rose(serial_clk) && cnt == 5'h0F);
  cover property ($fell(async_clear_n));
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  import sdwl_pkg::*;
  logic        clk_sys   = 1'b0;
  logic        rstn      = 1'b0;
  logic        req_valid = 1'b0;
  logic [13:0] req_code  = 14'h0000;
  logic        clear_req = 1'b0;
  logic        req_ready;
  logic [13:0] lc;
  logic [13:0] lcs;
  logic [13:0] blc;
  logic        le;
  logic        ble;
  int          n_fail    = 0;
  int          checked   = 0;
  sdwl_link_if link ();
  sdwl_link_if bad ();
  always #20 clk_sys = ~clk_sys;
  sdwl_host sdwl_host_inst (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .req_valid(req_valid),
    .req_code(req_code), .req_ready(req_ready), .clear_req(clear_req), .link(link.host));
  sdwl_device sdwl_device_inst (.link(link.device), .rstn(rstn), .clk_en(1'b1), .clk_sys(clk_sys),
    .latch_code(lc), .latch_code_sys(lcs), .load_err(le));
  // Second device faces a hand-driven link that can break framing
  sdwl_device #(.BIPOLAR(1'b1)) sdwl_device_inst_b (.link(bad.device), .rstn(rstn), .clk_en(1'b1),
    .clk_sys(clk_sys), .latch_code(blc), .latch_code_sys(), .load_err(ble));
  sdwl_props sdwl_props_inst (.clk_sys(clk_sys), .rstn(rstn), .frame_n(link.frame_n),
    .serial_clk(link.serial_clk), .serial_data(link.serial_data), .async_clear_n(link.async_clear_n));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One word through the host; each code must differ from the last
  task send(input logic [13:0] c);
    int i;
    for (i = 0; i < 400 && req_ready !== 1'b1; i++) @(posedge clk_sys) #1;
    if (i == 400) begin
      n_fail++;
      tally_and_finish;
    end
    req_valid = 1'b1;
    req_code  = c;
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
    for (i = 0; i < 400 && lcs !== c; i++) @(posedge clk_sys) #1;
    if (i == 400) begin
      n_fail++;
      tally_and_finish;
    end
    `CHK("latch", c, lc)
    `CHK("load_err", 1'b0, le)
  endtask
  task t_load;
    send(14'h3FFF);
    send(14'h0000);
    send(14'h2AAA);
    send(14'h1555);
    send(14'h2000);
    $display("t_load done");
  endtask
  task t_clear;
    clear_req = 1'b1;
    repeat (2) @(posedge clk_sys) #1;
    `CHK("clear", SDWL_CODE_UNIPOLAR, lc)
    `CHK("ready", 1'b0, req_ready)
    clear_req = 1'b0;
    send(14'h0ABC);
    $display("t_clear done");
  endtask
  // Hand-made frame at an 80 ns link period; hi keeps the select high
  task frame(input logic hi, input int n, input logic [15:0] w);
    int i;
    bad.frame_n = hi;
    #40;
    for (i = 0; i < n; i++) begin
      bad.serial_data = w[15-i];
      #20 bad.serial_clk = 1'b1;
      #40 bad.serial_clk = 1'b0;
      #20;
    end
    bad.frame_n = 1'b1;
    bad.serial_data = ~bad.serial_data;
    repeat (6) @(posedge clk_sys) #1;
  endtask
  task t_fault;
    `CHK("bip_reset", SDWL_CODE_BIPOLAR, blc)
    frame(1'b0, 16, 16'h48D0);
    `CHK("bip_load", 14'h1234, blc)
    frame(1'b0, 10, 16'hFFC0);
    `CHK("short", 14'h1234, blc)
    `CHK("short_err", 1'b1, ble)
    frame(1'b1, 16, 16'hFFFC);
    `CHK("no_select", 14'h1234, blc)
    frame(1'b0, 16, 16'h1DDC);
    `CHK("reload", 14'h0777, blc)
    `CHK("reload_err", 1'b0, ble)
    bad.async_clear_n = 1'b0;
    #20;
    `CHK("bip_clear", SDWL_CODE_BIPOLAR, blc)
    bad.async_clear_n = 1'b1;
    $display("t_fault done");
  endtask
  initial begin
    bad.frame_n       = 1'b1;
    bad.serial_clk    = 1'b0;
    bad.serial_data   = 1'b0;
    bad.async_clear_n = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1 rstn = 1'b1;
    `CHK("uni_reset", SDWL_CODE_UNIPOLAR, lc)
    t_load;
    t_clear;
    t_fault;
    tally_and_finish;
  end
endmodule
